// ===== dv/can_proto_model.sv
// behavioural protocol engine and bus partner for the can low-power block
`timescale 1ns/1ps
module can_proto_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [can_irq_pkg::NTXB-1:0] tx_pending,
   input wire logic [8:0] rx_err_set,
   input wire logic [8:0] tx_err_set,
   input wire logic rx_go,
   input wire logic ovr_go,
   input wire logic act,
   output can_irq_pkg::proto_s proto
);
   import can_irq_pkg::*;
   logic [2:0] rx_cnt;
   logic [2:0] tx_cnt;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         proto <= '0;
         rx_cnt <= '0;
         tx_cnt <= '0;
      end else begin
         proto.rx_err <= rx_err_set;
         proto.tx_err <= tx_err_set;
         proto.overrun_evt <= ovr_go;
         proto.bus_activity <= act;
         proto.rx_done_evt <= 1'b0;
         proto.tx_done_evt <= '0;
         proto.rx_busy <= rx_go || rx_cnt > 3'd1;
         proto.tx_busy <= tx_cnt != 3'd0;
         // frames only advance while the engine clock runs
         if (rx_go && rx_cnt == 3'd0) begin
            rx_cnt <= 3'd7;
         end else if (rx_cnt != 3'd0 && clk_en) begin
            rx_cnt <= rx_cnt - 3'd1;
            proto.rx_done_evt <= rx_cnt == 3'd1;
         end
         // no restart while the done pulse is still in flight
         if (tx_cnt == 3'd0 && tx_pending != '0 && proto.tx_done_evt == '0 && clk_en) begin
            tx_cnt <= 3'd5;
         end else if (tx_cnt != 3'd0 && clk_en) begin
            tx_cnt <= tx_cnt - 3'd1;
            if (tx_cnt == 3'd1) begin
               proto.tx_done_evt <= tx_pending & (~tx_pending + 1'b1);
            end
         end
      end
   end
endmodule : can_proto_model

// ===== dv/test_can_irq_lowpower_ctrl.sv
// self-checking bench for the can interrupt and low-power block
`timescale 1ns/1ps
module test_can_irq_lowpower_ctrl;
   import can_irq_pkg::*;
   logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, rx_go = 0, ovr_go = 0, act = 0, cpu_stop = 0;
   logic [7:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = '0;
   logic [31:0] hwdata = '0, hrdata, q, seed = 32'h0000_000A;
   logic hreadyout, hresp, pce, frec;
   logic [8:0] rxe = '0, txe = '0;
   logic [NTXB-1:0] tp;
   logic [31:0] cv [4];
   proto_s proto;
   irq_s irq;
   mode_e mode;
   int fail_count = 0, samples_checked = 0, cyc = 0;
   always #2.5 clk = ~clk;
   can_irq_lowpower_ctrl dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .proto(proto),
      .cpu_stop(cpu_stop), .irq(irq), .mode(mode), .proto_clk_en(pce),
      .transmit_line_force_recessive(frec), .tx_pending(tp));
   can_proto_model pm_u (.clk(clk), .rstn(rstn), .clk_en(pce), .tx_pending(tp),
      .rx_err_set(rxe), .tx_err_set(txe), .rx_go(rx_go), .ovr_go(ovr_go), .act(act),
      .proto(proto));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic cy(input int n);
      repeat (n) @(posedge clk);
   endtask : cy
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, q, e);
   endtask : rc
   task automatic wm(input mode_e m);
      for (int i = 0; i < 50 && mode !== m; i++) @(posedge clk);
   endtask : wm
   initial begin
      cy(12);
      rstn <= 1'b1;
      cy(1);
      chk("mode", 32'(mode), 32'(M_SOFTRES));
      chk("recessive", {31'h0, frec}, 32'h1);
      rc(A_FLAG, 32'(FLAG_RST), "flags");
      rc(A_MODCTL, CFG_RST, "modctl");
      for (int i = 0; i < 4; i++) begin
         cv[i] = rnd() & 32'h0000_00FF;
         wr(A_BITTIM + 8'(4 * i), cv[i]);
      end
      wr(A_MODCTL, 32'h0);
      wm(M_NORMAL);
      chk("mode", 32'(mode), 32'(M_NORMAL));
      chk("clken", {31'h0, pce}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         wr(A_BITTIM + 8'(4 * i), ~cv[i]);
         rc(A_BITTIM + 8'(4 * i), cv[i], "locked");
      end
      $display("test lock done");
      rxe <= 9'd95;
      txe <= 9'(rnd() % 32'd96);
      cy(3);
      rc(A_FLAG, 32'h0000_0700, "below warn");
      rxe <= 9'd96;
      txe <= 9'd128;
      cy(3);
      rc(A_FLAG, 32'h0000_0716, "warn pass");
      txe <= 9'd256;
      cy(3);
      rc(A_FLAG, 32'h0000_0736, "bus off");
      rc(A_ERRCNT, {7'h0, 9'd256, 7'h0, 9'd96}, "errcnt");
      wr(A_ERRCNT, 32'hFFFF_FFFF);
      rc(A_ERRCNT, {7'h0, 9'd256, 7'h0, 9'd96}, "errcnt ro");
      wr(A_FLAG, 32'h0000_0036);
      rc(A_FLAG, 32'h0000_0736, "held");
      rxe <= 9'd0;
      txe <= 9'd0;
      cy(2);
      wr(A_FLAG, 32'h0);
      rc(A_FLAG, 32'h0000_0736, "zero write");
      wr(A_FLAG, 32'h0000_0036);
      rc(A_FLAG, 32'h0000_0700, "cleared");
      $display("test error flags done");
      ovr_go <= 1'b1;
      cy(1);
      ovr_go <= 1'b0;
      cy(2);
      rc(A_FLAG, 32'h0000_0740, "overrun");
      chk("irq err off", {31'h0, irq.err}, 32'h0);
      wr(A_ENABLE, 32'h0000_0040);
      cy(2);
      chk("irq err", {31'h0, irq.err}, 32'h1);
      chk("irq tx off", {31'h0, irq.tx}, 32'h0);
      wr(A_FLAG, 32'h0000_0040);
      cy(2);
      chk("irq err clr", {31'h0, irq.err}, 32'h0);
      wr(A_ENABLE, 32'h0000_01C0);
      cy(2);
      chk("irq tx", {31'h0, irq.tx}, 32'h1);
      wr(A_FLAG, 32'h0000_0100);
      cy(2);
      chk("pending", 32'(tp), 32'h1);
      chk("irq tx drop", {31'h0, irq.tx}, 32'h0);
      cy(10);
      rc(A_FLAG, 32'h0000_0700, "tx done");
      chk("irq tx back", {31'h0, irq.tx}, 32'h1);
      rx_go <= 1'b1;
      cy(1);
      rx_go <= 1'b0;
      cy(12);
      rc(A_FLAG, 32'h0000_0780, "rx full");
      chk("irq rx", {31'h0, irq.rx}, 32'h1);
      wr(A_FLAG, 32'h0000_0080);
      $display("test interrupts done");
      rx_go <= 1'b1;
      cy(1);
      rx_go <= 1'b0;
      wr(A_MODCTL, 32'h2);
      rc(A_MODCTL, 32'h2, "ack wait");
      wr(A_MODCTL, 32'h0);
      rc(A_MODCTL, 32'h2, "early clear");
      wm(M_SLEEP);
      chk("sleep", 32'(mode), 32'(M_SLEEP));
      rc(A_MODCTL, 32'h6, "ack");
      chk("sleep clk", {31'h0, pce}, 32'h0);
      chk("sleep tx", {31'h0, frec}, 32'h1);
      wr(A_ENABLE, 32'h1);
      act <= 1'b1;
      cy(1);
      act <= 1'b0;
      wm(M_NORMAL);
      chk("woken", 32'(mode), 32'(M_NORMAL));
      rc(A_FLAG, 32'h0000_0781, "wake flag");
      chk("irq wake", {31'h0, irq.wake}, 32'h0);
      wr(A_MODCTL, 32'h2);
      wm(M_SLEEP);
      chk("irq wake on", {31'h0, irq.wake}, 32'h1);
      wr(A_MODCTL, 32'h0);
      wm(M_NORMAL);
      chk("sw wake", 32'(mode), 32'(M_NORMAL));
      wr(A_FLAG, 32'h0000_0100);
      cy(2);
      wr(A_MODCTL, 32'h2);
      cy(1);
      rc(A_MODCTL, 32'h2, "tx wait");
      wm(M_SLEEP);
      chk("sleep after tx", 32'(mode), 32'(M_SLEEP));
      rc(A_FLAG, 32'h0000_0781, "sent first");
      cpu_stop <= 1'b1;
      wm(M_PWRDN);
      chk("pwrdn", 32'(mode), 32'(M_PWRDN));
      chk("pd tx", {31'h0, frec}, 32'h1);
      chk("pd clk", {31'h0, pce}, 32'h0);
      rc(A_FLAG, 32'h0, "pd read");
      wr(A_FLAG, 32'h0000_0781);
      cpu_stop <= 1'b0;
      wm(M_SLEEP);
      rc(A_FLAG, 32'h0000_0781, "pd write");
      $display("test low power done");
      complete_run();
   end
endmodule : test_can_irq_lowpower_ctrl

// ===== rtl/can_irq_lowpower_ctrl.sv
// can interrupt, protection and low-power control with ahb-lite register slave
//
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module can_irq_lowpower_ctrl (
   input wire logic clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire can_irq_pkg::proto_s proto,
   input wire logic cpu_stop,
   output can_irq_pkg::irq_s irq,
   output can_irq_pkg::mode_e mode,
   output logic proto_clk_en,
   output logic transmit_line_force_recessive,
   output logic [can_irq_pkg::NTXB-1:0] tx_pending
);
   import can_irq_pkg::*;

   logic [NSRC-1:0] flags;
   logic [NSRC-1:0] enables;
   logic [31:0] modctl;
   logic [31:0] bittim;
   logic [31:0] accctl;
   logic [31:0] acccode;
   logic [31:0] accmask;
   logic sleep_request_bit;
   logic sleep_ack_flag;
   logic soft_reset_lock_bit;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [NSRC-1:0] cond;
   logic [NSRC-1:0] set_evt;
   logic [NSRC-1:0] clr_req;
   logic wr_flag;
   logic bus_off;

   assign soft_reset_lock_bit = modctl[B_SOFT_RESET_LOCK_BIT];
   assign bus_off = proto.tx_err > LIM_BOFF;

   // ahb-lite slave: zero wait states, always okay
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else if (hready) begin
         wr_pend <= hsel && htrans == HTRANS_NONSEQ && hwrite && hsize == HSIZE_WORD
                    && mode != M_PWRDN;
         wr_addr <= haddr;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
         if (mode == M_PWRDN) begin
            hrdata <= 32'h0000_0000;
         end else begin
            case (haddr)
               A_FLAG: hrdata <= {21'h00_0000, flags};
               A_ENABLE: hrdata <= {21'h00_0000, enables};
               A_MODCTL: hrdata <= {modctl[31:3], sleep_ack_flag, sleep_request_bit,
                                    soft_reset_lock_bit};
               A_BITTIM: hrdata <= bittim;
               A_ACCCTL: hrdata <= accctl;
               A_ACCCODE: hrdata <= acccode;
               A_ACCMASK: hrdata <= accmask;
               A_ERRCNT: hrdata <= {7'h00, proto.tx_err, 7'h00, proto.rx_err};
               A_STATUS: hrdata <= {30'h0000_0000, mode};
               A_TXCTL: hrdata <= {29'h0000_0000, tx_pending};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // configuration lock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         modctl <= CFG_RST;
         bittim <= 32'h0000_0000;
         accctl <= 32'h0000_0000;
         acccode <= 32'h0000_0000;
         accmask <= 32'h0000_0000;
      end else if (wr_pend && soft_reset_lock_bit) begin
         case (wr_addr)
            A_MODCTL: modctl <= {hwdata[31:3], 2'b00, hwdata[B_SOFT_RESET_LOCK_BIT]};
            A_BITTIM: bittim <= hwdata;
            A_ACCCTL: accctl <= hwdata;
            A_ACCCODE: acccode <= hwdata;
            A_ACCMASK: accmask <= hwdata;
            default: ;
         endcase
      end else if (wr_pend && wr_addr == A_MODCTL && hwdata[B_SOFT_RESET_LOCK_BIT]) begin
         modctl[B_SOFT_RESET_LOCK_BIT] <= 1'b1; // going off-line is always allowed
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         enables <= '0;
      end else if (wr_pend && wr_addr == A_ENABLE) begin
         enables <= hwdata[NSRC-1:0];
      end
   end

   // sleep request: set any time, cleared only after ack
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sleep_request_bit <= 1'b0;
      end else if (wr_pend && wr_addr == A_MODCTL) begin
         if (hwdata[B_SLEEP_REQUEST_BIT]) begin
            sleep_request_bit <= 1'b1;
         end else if (sleep_ack_flag) begin
            sleep_request_bit <= 1'b0;
         end
      end else if (sleep_ack_flag && proto.bus_activity) begin
         sleep_request_bit <= 1'b0;
      end
   end

   // sleep ack: enter when idle, no pending tx, not receiving
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sleep_ack_flag <= 1'b0;
      end else if (!sleep_request_bit || (sleep_ack_flag && proto.bus_activity)) begin
         sleep_ack_flag <= 1'b0;
      end else if (!proto.rx_busy && !proto.tx_busy && tx_pending == '0) begin
         sleep_ack_flag <= 1'b1;
      end
   end

   // mode and pin control
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode <= M_SOFTRES;
         proto_clk_en <= 1'b0;
         transmit_line_force_recessive <= 1'b1;
      end else begin
         if (cpu_stop) begin
            mode <= M_PWRDN;
         end else if (soft_reset_lock_bit) begin
            mode <= M_SOFTRES;
         end else if (sleep_ack_flag) begin
            mode <= M_SLEEP;
         end else begin
            mode <= M_NORMAL;
         end
         proto_clk_en <= !cpu_stop && !soft_reset_lock_bit && !sleep_ack_flag;
         transmit_line_force_recessive <= cpu_stop || soft_reset_lock_bit
                                          || sleep_ack_flag;
      end
   end

   // set conditions of each flag
   always_comb begin
      cond = '0;
      set_evt = '0;
      cond[B_RXWRN] = proto.rx_err >= LIM_WARN;
      cond[B_TXWRN] = proto.tx_err >= LIM_WARN;
      cond[B_RXPAS] = proto.rx_err > LIM_PASS;
      cond[B_TXPAS] = proto.tx_err > LIM_PASS;
      cond[B_BOFF] = bus_off;
      set_evt = cond;
      set_evt[B_WAKE] = sleep_ack_flag && proto.bus_activity;
      set_evt[B_OVR] = proto.overrun_evt;
      set_evt[B_RXF] = proto.rx_done_evt;
      set_evt[B_TX_EMPTY_FLAG_ZERO +: NTXB] = proto.tx_done_evt;
   end

   assign wr_flag = wr_pend && wr_addr == A_FLAG && mode != M_PWRDN;
   assign clr_req = wr_flag ? hwdata[NSRC-1:0] : '0;

   generate
      for (genvar i = 0; i < NSRC; i++) begin : g_flag
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               flags[i] <= FLAG_RST[i];
            end else if (set_evt[i] || cond[i]) begin
               flags[i] <= 1'b1;
            end else if (clr_req[i]) begin
               flags[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // tx buffer release: writing one to an empty flag schedules that buffer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_pending <= '0;
      end else begin
         tx_pending <= (tx_pending & ~proto.tx_done_evt)
                       | (clr_req[B_TX_EMPTY_FLAG_ZERO +: NTXB] & ~proto.tx_done_evt);
      end
   end

   // interrupt requests
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq <= '0;
      end else begin
         irq.wake <= flags[B_WAKE] && enables[B_WAKE] && sleep_ack_flag;
         irq.err <= |(flags[B_OVR:B_RXWRN] & enables[B_OVR:B_RXWRN]);
         irq.rx <= flags[B_RXF] && enables[B_RXF];
         irq.tx <= |(flags[B_TX_EMPTY_FLAG_ZERO +: NTXB] & enables[B_TX_EMPTY_FLAG_ZERO +: NTXB]);
      end
   end

   // named steps of the sleep, wake and bus handshakes
   sequence s_sleep_ready;
      sleep_request_bit && !proto.rx_busy && !proto.tx_busy && tx_pending == '0
         && !(sleep_ack_flag && proto.bus_activity);
   endsequence
   sequence s_sleep_grant;
      sleep_ack_flag && !soft_reset_lock_bit && !cpu_stop;
   endsequence
   sequence s_bus_wake;
      sleep_ack_flag && proto.bus_activity;
   endsequence
   sequence s_sw_wake;
      wr_pend && wr_addr == A_MODCTL && !hwdata[B_SLEEP_REQUEST_BIT] && sleep_ack_flag;
   endsequence
   sequence s_early_clear;
      wr_pend && wr_addr == A_MODCTL && !hwdata[B_SLEEP_REQUEST_BIT] && !sleep_ack_flag;
   endsequence
   sequence s_pd_read;
      hready && hsel && htrans == HTRANS_NONSEQ && !hwrite && mode == M_PWRDN;
   endsequence
   sequence s_cnt_read;
      hready && hsel && htrans == HTRANS_NONSEQ && !hwrite && haddr == A_ERRCNT
         && mode != M_PWRDN;
   endsequence

   // flags and interrupt requests
   a_err_irq_hold: assert property (@(posedge clk) disable iff (!rstn)
      |(flags[B_OVR:B_RXWRN] & enables[B_OVR:B_RXWRN]) |=> irq.err)
      else $error("error irq not raised");
   a_rx_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
      !enables[B_RXF] |=> !irq.rx)
      else $error("masked rx irq raised");
   a_warn_set: assert property (@(posedge clk) disable iff (!rstn)
      proto.rx_err >= LIM_WARN |=> flags[B_RXWRN])
      else $error("rx warning missing");
   a_passive_set: assert property (@(posedge clk) disable iff (!rstn)
      proto.tx_err > LIM_PASS |=> flags[B_TXPAS])
      else $error("tx passive missing");
   a_busoff_set: assert property (@(posedge clk) disable iff (!rstn)
      proto.tx_err > LIM_BOFF |=> flags[B_BOFF])
      else $error("bus off missing");
   a_overrun_set: assert property (@(posedge clk) disable iff (!rstn)
      proto.overrun_evt |=> flags[B_OVR])
      else $error("overrun missing");
   a_zero_keeps: assert property (@(posedge clk) disable iff (!rstn)
      wr_flag && !hwdata[B_RXF] && flags[B_RXF] |=> flags[B_RXF])
      else $error("zero write cleared flag");
   a_wake_gate: assert property (@(posedge clk) disable iff (!rstn)
      irq.wake |-> $past(sleep_ack_flag) && $past(enables[B_WAKE]))
      else $error("wake irq without ack");
   a_txwarn_set: assert property (@(posedge clk) disable iff (!rstn)
      proto.tx_err >= LIM_WARN |=> flags[B_TXWRN])
      else $error("tx warning missing");
   a_rxpass_set: assert property (@(posedge clk) disable iff (!rstn)
      proto.rx_err > LIM_PASS |=> flags[B_RXPAS])
      else $error("rx passive missing");
   a_clear_held: assert property (@(posedge clk) disable iff (!rstn)
      wr_flag && cond[B_BOFF] |=> flags[B_BOFF])
      else $error("held flag cleared");
   a_ovr_clear: assert property (@(posedge clk) disable iff (!rstn)
      wr_flag && hwdata[B_OVR] && !proto.overrun_evt |=> !flags[B_OVR])
      else $error("overrun clear lost");
   a_rxf_clear: assert property (@(posedge clk) disable iff (!rstn)
      wr_flag && hwdata[B_RXF] && !proto.rx_done_evt |=> !flags[B_RXF])
      else $error("rx full clear lost");
   a_tx_release: assert property (@(posedge clk) disable iff (!rstn)
      wr_flag && hwdata[B_TX_EMPTY_FLAG_ZERO] && !proto.tx_done_evt[0] |=> tx_pending[0] && !flags[B_TX_EMPTY_FLAG_ZERO])
      else $error("tx buffer not released");
   a_rx_irq_hold: assert property (@(posedge clk) disable iff (!rstn)
      flags[B_RXF] && enables[B_RXF] |=> irq.rx)
      else $error("rx irq not raised");
   a_tx_irq_hold: assert property (@(posedge clk) disable iff (!rstn)
      |(flags[B_TX_EMPTY_FLAG_ZERO +: NTXB] & enables[B_TX_EMPTY_FLAG_ZERO +: NTXB]) |=> irq.tx)
      else $error("tx irq not raised");
   a_err_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
      !(|(flags[B_OVR:B_RXWRN] & enables[B_OVR:B_RXWRN])) |=> !irq.err)
      else $error("masked error irq raised");
   a_tx_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
      !(|(flags[B_TX_EMPTY_FLAG_ZERO +: NTXB] & enables[B_TX_EMPTY_FLAG_ZERO +: NTXB])) |=> !irq.tx)
      else $error("masked tx irq raised");
   a_wake_irq: assert property (@(posedge clk) disable iff (!rstn)
      flags[B_WAKE] && enables[B_WAKE] && sleep_ack_flag |=> irq.wake)
      else $error("wake irq not raised");

   // configuration lock and error counters
   a_cfg_lock: assert property (@(posedge clk) disable iff (!rstn)
      !soft_reset_lock_bit |=> $stable(bittim))
      else $error("locked config changed");
   a_acc_lock: assert property (@(posedge clk) disable iff (!rstn)
      !soft_reset_lock_bit |=> $stable(accctl) && $stable(acccode) && $stable(accmask))
      else $error("locked filter changed");
   a_modctl_lock: assert property (@(posedge clk) disable iff (!rstn)
      !soft_reset_lock_bit |=> $stable(modctl[31:B_SLEEP_REQUEST_BIT]))
      else $error("locked module control changed");
   a_cnt_read: assert property (@(posedge clk) disable iff (!rstn)
      s_cnt_read |=> hrdata == {7'h00, $past(proto.tx_err), 7'h00, $past(proto.rx_err)})
      else $error("error counter read wrong");

   // mode, sleep and power-down
   a_pwrdn_mode: assert property (@(posedge clk) disable iff (!rstn)
      cpu_stop |=> mode == M_PWRDN && transmit_line_force_recessive)
      else $error("power down not entered");
   a_sleep_tx_rec: assert property (@(posedge clk) disable iff (!rstn)
      mode == M_SLEEP |-> transmit_line_force_recessive && !proto_clk_en)
      else $error("sleep line not recessive");
   a_sleep_request_bit_hold: assert property (@(posedge clk) disable iff (!rstn)
      sleep_request_bit && !sleep_ack_flag |=> sleep_request_bit)
      else $error("sleep request cleared early");
   a_sleep_entry: assert property (@(posedge clk) disable iff (!rstn)
      s_sleep_ready |=> sleep_ack_flag)
      else $error("sleep ack not given");
   a_sleep_mode: assert property (@(posedge clk) disable iff (!rstn)
      s_sleep_grant |=> mode == M_SLEEP && transmit_line_force_recessive)
      else $error("sleep mode not entered");
   a_ack_hold: assert property (@(posedge clk) disable iff (!rstn)
      sleep_ack_flag && sleep_request_bit && !proto.bus_activity |=> sleep_ack_flag)
      else $error("sleep ack dropped");
   a_bus_wake: assert property (@(posedge clk) disable iff (!rstn)
      s_bus_wake |=> !sleep_ack_flag && flags[B_WAKE] ##1 mode != M_SLEEP)
      else $error("bus activity did not wake");
   a_sw_wake: assert property (@(posedge clk) disable iff (!rstn)
      s_sw_wake |=> !sleep_request_bit ##1 !sleep_ack_flag)
      else $error("software wake failed");
   a_early_clear: assert property (@(posedge clk) disable iff (!rstn)
      s_early_clear |=> $stable(sleep_request_bit))
      else $error("early clear changed request");
   a_softres_mode: assert property (@(posedge clk) disable iff (!rstn)
      !cpu_stop && soft_reset_lock_bit |=> mode == M_SOFTRES && !proto_clk_en)
      else $error("soft reset mode wrong");
   a_softres_line: assert property (@(posedge clk) disable iff (!rstn)
      mode == M_SOFTRES |-> transmit_line_force_recessive)
      else $error("soft reset line not recessive");
   a_normal_mode: assert property (@(posedge clk) disable iff (!rstn)
      !cpu_stop && !soft_reset_lock_bit && !sleep_ack_flag |=> mode == M_NORMAL && proto_clk_en)
      else $error("normal mode wrong");
   a_pd_clk_off: assert property (@(posedge clk) disable iff (!rstn)
      cpu_stop |=> !proto_clk_en)
      else $error("power down clock running");
   a_pd_line: assert property (@(posedge clk) disable iff (!rstn)
      mode == M_PWRDN |-> transmit_line_force_recessive && !proto_clk_en)
      else $error("power down line not recessive");
   a_pd_no_write: assert property (@(posedge clk) disable iff (!rstn)
      hready && mode == M_PWRDN |=> !wr_pend)
      else $error("power down write taken");
   a_pd_read: assert property (@(posedge clk) disable iff (!rstn)
      s_pd_read |=> hrdata == '0)
      else $error("power down read not zero");
endmodule : can_irq_lowpower_ctrl

// ===== rtl/can_irq_pkg.sv
// package: register map, field positions, states and carriers for the can interrupt/low-power block
package can_irq_pkg;
   localparam logic [7:0] A_FLAG = 8'h00;
   localparam logic [7:0] A_ENABLE = 8'h04;
   localparam logic [7:0] A_TXCTL = 8'h08;
   localparam logic [7:0] A_MODCTL = 8'h0C;
   localparam logic [7:0] A_BITTIM = 8'h10;
   localparam logic [7:0] A_ACCCTL = 8'h14;
   localparam logic [7:0] A_ACCCODE = 8'h18;
   localparam logic [7:0] A_ACCMASK = 8'h1C;
   localparam logic [7:0] A_ERRCNT = 8'h20;
   localparam logic [7:0] A_STATUS = 8'h24;
   // flag / enable bit positions in A_FLAG and A_ENABLE
   localparam int B_WAKE = 0;
   localparam int B_RXWRN = 1;
   localparam int B_TXWRN = 2;
   localparam int B_RXPAS = 3;
   localparam int B_TXPAS = 4;
   localparam int B_BOFF = 5;
   localparam int B_OVR = 6;
   localparam int B_RXF = 7;
   localparam int B_TX_EMPTY_FLAG_ZERO = 8;
   localparam int NSRC = 11;
   localparam int NTXB = 3;
   // module control bits
   localparam int B_SOFT_RESET_LOCK_BIT = 0;
   localparam int B_SLEEP_REQUEST_BIT = 1;
   localparam int B_SLEEP_ACK_FLAG = 2;
   localparam logic [8:0] LIM_WARN = 9'h060;
   localparam logic [8:0] LIM_PASS = 9'h07F;
   localparam logic [8:0] LIM_BOFF = 9'h0FF;
   localparam logic [NSRC-1:0] FLAG_RST = 11'h700;
   localparam logic [31:0] CFG_RST = 32'h0000_0001;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   typedef enum logic [1:0] {M_NORMAL, M_SLEEP, M_SOFTRES, M_PWRDN} mode_e;
   typedef struct packed {
      logic [8:0] rx_err;
      logic [8:0] tx_err;
      logic overrun_evt;
      logic rx_done_evt;
      logic [NTXB-1:0] tx_done_evt;
      logic rx_busy;
      logic tx_busy;
      logic bus_activity;
   } proto_s;
   typedef struct packed {
      logic wake;
      logic err;
      logic rx;
      logic tx;
   } irq_s;
endpackage : can_irq_pkg
